// ===== hdl/dvm_params.svh
// Offsets, field positions, reset values and timing counts of the mode block
`ifndef DVM_PARAMS_SVH
`define DVM_PARAMS_SVH
`define DVM_CLK_HZ        40000000
`define DVM_TICK_US       1000
`define DVM_TICK_CYC      ((`DVM_CLK_HZ / 1000000) * `DVM_TICK_US)
`define DVM_NREG          40
`define DVM_R_MODE        0
`define DVM_R_CTRL        1
`define DVM_R_STATUS      2
`define DVM_R_PROF_TYPE   3
`define DVM_R_TGT_PV      4
`define DVM_R_MAX_PVEL    5
`define DVM_R_MAX_MOTOR   6
`define DVM_R_PROF_VEL    7
`define DVM_R_END_VEL     8
`define DVM_R_PROF_ACC    9
`define DVM_R_PROF_DEC    10
`define DVM_R_QS_DEC      11
`define DVM_R_MAX_ACC     12
`define DVM_R_MAX_DEC     13
`define DVM_R_JERK0       14
`define DVM_R_DIM_MUL     18
`define DVM_R_DIM_DIV     19
`define DVM_R_VL_ACC_DS   20
`define DVM_R_VL_ACC_DT   21
`define DVM_R_VL_DEC_DS   22
`define DVM_R_VL_DEC_DT   23
`define DVM_R_VL_QS_DS    24
`define DVM_R_VL_QS_DT    25
`define DVM_R_VL_MIN      26
`define DVM_R_VL_MAX      27
`define DVM_R_VEL_WIN     28
`define DVM_R_VEL_WIN_T   29
`define DVM_R_VEL_THR     30
`define DVM_R_VEL_THR_T   31
`define DVM_R_MAX_SLIP    32
`define DVM_R_SLIP_T      33
`define DVM_R_POS_MIN     34
`define DVM_R_POS_MAX     35
`define DVM_R_TGT_POS     36
`define DVM_R_TGT_VL      37
`define DVM_R_DEMAND      38
`define DVM_R_POSITION    39
`define DVM_MODE_POS      8'h01
`define DVM_MODE_VL       8'h02
`define DVM_MODE_PV       8'h03
`define DVM_PROF_TRAP     32'h00000000
`define DVM_PROF_JERK     32'h00000003
`define DVM_DIM_RST       32'h00000001
`define DVM_B_CLOSED      0
`define DVM_B_HALT        8
`define DVM_B_REACHED     10
`define DVM_B_LIMIT       11
`define DVM_B_ZERO        12
`define DVM_B_DEVIATE     13
`endif

// ===== hdl/dvm_pkg.sv
// Types shared by the mode control block
`default_nettype none
package dvm_pkg;
  typedef enum logic [3:0] {
    DVM_IDLE = 4'h1,
    DVM_POS  = 4'h2,
    DVM_VL   = 4'h4,
    DVM_PV   = 4'h8
  } dvm_mode_t;
  typedef logic signed [31:0] dvm_word_t;
  typedef logic signed [63:0] dvm_wide_t;
endpackage : dvm_pkg
`default_nettype wire

// ===== hdl/dvm_mode_ctrl.sv
// Motion mode control: ramp generator, limits and status behind an APB slave
//
// Behaviour
// (RQ1) Profile type 3 limits jerk with four jerk values; type 0 applies none. Code applies only the accel rise and decel rise values.
// (RQ2) Profile type resets to 0, a trapezoidal ramp.
// (RQ3) Commanded speed capped at smaller of max profile and max motor speed.
// (RQ4) Positioning approaches at profile velocity, arrives at end velocity.
// (RQ5) Max acceleration and max deceleration are never exceeded in positioning.
// (RQ6) Quick stop active brakes with quick stop deceleration.
// (RQ7) Position wraps modulo the position range limits.
// (RQ8) Mode value 2 selects velocity mode.
// (RQ9) Velocity mode uses linear ramps only, never jerk limiting.
// (RQ10) Velocity mode halt stops via deceleration ramp, restarts via acceleration.
// (RQ11) Velocity mode status bit 11 high while any limit constrains ramp.
// (RQ12) User speed converts to rpm by multiplier and divisor.
// (RQ13) Velocity acceleration is delta speed over delta time.
// (RQ14) Software gives deceleration delta speed as positive value.
// (RQ15) Velocity mode raises target below minimum to minimum.
// (RQ16) Velocity mode cuts target above maximum to maximum.
// (RQ17) Velocity quick stop ramp from its own delta speed and time.
// (RQ18) Mode value 3 selects profile velocity mode with jerk ramps.
// (RQ19) Profile velocity halt brakes to standstill, release uses start ramp.
// (RQ20) Profile velocity bit 10: reached/standstill per halt, else 0.
// (RQ21) Bit 12 clears after speed above threshold for threshold time.
// (RQ22) Closed loop bit 13 sets after slippage above max for timeout.
// (RQ23) Target reached only after speed stays in window for window time.
// (RQ24) Demand updates once per tick, step at most rate times tick.
`default_nettype none
`include "dvm_params.svh"
module dvm_mode_ctrl
  import dvm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `DVM_TICK_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output      logic        pready,
  output var  logic        pslverr,
  // Power stage and feedback
  input  wire logic        quick_stop_active,
  input  wire logic [31:0] actual_speed,
  output var  logic [31:0] demand_speed,
  output var  logic [31:0] demand_position,
  output var  logic [15:0] status_word
);

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  logic [31:0] regs [0:`DVM_NREG-1];
  logic [31:0] act_meta;
  logic [31:0] act_sync;
  logic        qs_meta;
  logic        qs_sync;
  logic [15:0] tick_cnt;
  logic        tick;
  dvm_mode_t   state;
  dvm_mode_t   next_state;
  dvm_word_t   dem;
  dvm_word_t   pos;
  dvm_word_t   cur_step;
  logic        limited;
  logic [15:0] win_cnt;
  logic [15:0] thr_cnt;
  logic [15:0] slip_cnt;

  function automatic dvm_word_t abs_w(input dvm_word_t v);
    abs_w = v[31] ? -v : v;
  endfunction : abs_w

  function automatic dvm_word_t min_w(input dvm_word_t a, input dvm_word_t b);
    min_w = (a < b) ? a : b;
  endfunction : min_w

  // Divide by zero reads as the plain numerator
  function automatic dvm_word_t ratio(input dvm_word_t a, input dvm_word_t b);
    ratio = (b == 32'sh00000000) ? a : 32'(a / b);
  endfunction : ratio

  // Per-second rate to per-tick step, never below one for a positive rate
  function automatic dvm_word_t per_tick(input dvm_word_t r);
    dvm_wide_t w;
    w = 64'(r) * 64'(`DVM_TICK_US) / 64'sh00000000000F4240;
    per_tick = (w == 64'sh0 && r > 32'sh0) ? 32'sh00000001 : 32'(w);
  endfunction : per_tick

  // Address decode of a word index
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[7:2] < 6'(`DVM_NREG)) && (a[1:0] == 2'h0);
  endfunction : mapped

  function automatic logic read_only(input logic [5:0] i);
    read_only = (i == 6'(`DVM_R_STATUS)) || (i == 6'(`DVM_R_DEMAND))
             || (i == 6'(`DVM_R_POSITION));
  endfunction : read_only

  // Synchronisers for the feedback word and the quick stop line
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      act_meta <= 32'h00000000;
      act_sync <= 32'h00000000;
      qs_meta  <= 1'b0;
      qs_sync  <= 1'b0;
    end else begin
      act_meta <= actual_speed;
      act_sync <= act_meta;
      qs_meta  <= quick_stop_active;
      qs_sync  <= qs_meta;
    end
  end

  // APB: zero wait states, read data latched in the setup cycle
  assign pready = psel & penable;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !mapped(paddr) || (pwrite && read_only(paddr[7:2]));
      if (pwrite || !mapped(paddr))
        prdata <= 32'h00000000;
      else if (paddr[7:2] == 6'(`DVM_R_STATUS))
        prdata <= {16'h0000, status_word};
      else if (paddr[7:2] == 6'(`DVM_R_DEMAND))
        prdata <= demand_speed;
      else if (paddr[7:2] == 6'(`DVM_R_POSITION))
        prdata <= demand_position;
      else
        prdata <= regs[paddr[7:2]];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `DVM_NREG; i++) begin
        if (i == `DVM_R_DIM_MUL || i == `DVM_R_DIM_DIV)
          regs[i] <= `DVM_DIM_RST;
        else if (i == `DVM_R_PROF_TYPE)
          regs[i] <= `DVM_PROF_TRAP; // [RQ2]
        else
          regs[i] <= 32'h00000000;
      end
    end else if (psel && penable && pwrite && mapped(paddr) && !read_only(paddr[7:2])) begin
      regs[paddr[7:2]] <= pwdata;
    end
  end

  // Mode selection follows the written mode value
  always_comb begin
    case (regs[`DVM_R_MODE][7:0])
      `DVM_MODE_POS: next_state = DVM_POS;
      `DVM_MODE_VL:  next_state = DVM_VL; // [RQ8]
      `DVM_MODE_PV:  next_state = DVM_PV; // [RQ18]
      default:       next_state = DVM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      state <= DVM_IDLE;
    else
      state <= next_state;
  end

  // Fixed control tick
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == TICK_LAST);
      tick_cnt <= (tick_cnt == TICK_LAST) ? 16'h0000 : tick_cnt + 16'h0001;
    end
  end

  // Ramp target and rate
  logic      halt;
  logic      jerk_on;
  logic      clamped;
  logic      braking;
  dvm_word_t vcap;
  dvm_word_t vl_tgt;
  dvm_word_t tgt;
  dvm_word_t rate;
  dvm_word_t err;
  dvm_word_t step_lim;
  dvm_word_t jerk_step;
  dvm_word_t step_use;
  dvm_word_t remain;
  dvm_word_t end_v;
  dvm_wide_t brake_d;
  logic [1:0] jidx;

  always_comb begin
    halt     = regs[`DVM_R_CTRL][`DVM_B_HALT];
    jerk_on  = (regs[`DVM_R_PROF_TYPE] == `DVM_PROF_JERK) && (state != DVM_VL); // [RQ1] [RQ9]
    vcap     = min_w(regs[`DVM_R_MAX_PVEL], regs[`DVM_R_MAX_MOTOR]); // [RQ3]
    clamped  = 1'b0;
    braking  = 1'b0;
    remain   = regs[`DVM_R_TGT_POS] - pos;
    end_v    = min_w(abs_w(regs[`DVM_R_END_VEL]), vcap);
    brake_d  = 64'sh0;
    vl_tgt   = ratio(32'(64'(dvm_word_t'(regs[`DVM_R_TGT_VL]))
               * 64'(dvm_word_t'(regs[`DVM_R_DIM_MUL]))),
               regs[`DVM_R_DIM_DIV]); // [RQ12]
    tgt      = 32'sh0;
    rate     = 32'sh0;
    case (state)
      DVM_VL: begin
        tgt = abs_w(vl_tgt);
        if (tgt < dvm_word_t'(regs[`DVM_R_VL_MIN])) begin
          tgt     = regs[`DVM_R_VL_MIN]; // [RQ15]
          clamped = 1'b1;
        end
        if (tgt > dvm_word_t'(regs[`DVM_R_VL_MAX])) begin
          tgt     = regs[`DVM_R_VL_MAX]; // [RQ16]
          clamped = 1'b1;
        end
        if (tgt > vcap) begin
          tgt     = vcap; // [RQ3]
          clamped = 1'b1;
        end
        tgt = vl_tgt[31] ? -tgt : tgt;
        if (halt)
          tgt = 32'sh0; // [RQ10]
        braking = abs_w(tgt) < abs_w(dem) || (tgt[31] != dem[31] && dem != 32'sh0);
        rate = braking
             ? ratio(abs_w(regs[`DVM_R_VL_DEC_DS]), regs[`DVM_R_VL_DEC_DT]) // [RQ14] [RQ10]
             : ratio(regs[`DVM_R_VL_ACC_DS], regs[`DVM_R_VL_ACC_DT]); // [RQ13]
        if (qs_sync) begin
          tgt  = 32'sh0;
          rate = ratio(regs[`DVM_R_VL_QS_DS], regs[`DVM_R_VL_QS_DT]); // [RQ17]
        end
      end
      DVM_PV, DVM_POS: begin
        if (state == DVM_PV) begin
          tgt = regs[`DVM_R_TGT_PV];
          if (abs_w(tgt) > vcap)
            tgt = tgt[31] ? -vcap : vcap; // [RQ3]
          if (halt)
            tgt = 32'sh0; // [RQ19]
        end else begin
          // Brake to end velocity once the remaining way runs short
          brake_d = (64'(dem) * 64'(dem) - 64'(end_v) * 64'(end_v))
                  / (64'(min_w(regs[`DVM_R_PROF_DEC], regs[`DVM_R_MAX_DEC])) * 64'sh2 + 64'sh1);
          tgt = (64'(abs_w(remain)) <= brake_d) ? end_v
              : min_w(regs[`DVM_R_PROF_VEL], vcap); // [RQ4]
          tgt = remain[31] ? -tgt : tgt;
          if (remain == 32'sh0)
            tgt = 32'sh0;
        end
        braking = abs_w(tgt) < abs_w(dem) || (tgt[31] != dem[31] && dem != 32'sh0);
        rate = braking ? min_w(regs[`DVM_R_PROF_DEC], regs[`DVM_R_MAX_DEC]) // [RQ5]
                       : min_w(regs[`DVM_R_PROF_ACC], regs[`DVM_R_MAX_ACC]); // [RQ5]
        if (qs_sync) begin
          tgt  = 32'sh0;
          rate = regs[`DVM_R_QS_DEC]; // [RQ6]
        end
      end
      default: begin
        tgt  = 32'sh0;
        rate = regs[`DVM_R_QS_DEC];
      end
    endcase
    err      = tgt - dem;
    step_lim = per_tick(rate); // [RQ24]
    // Jerk values: accel rise, accel fall, decel rise, decel fall
    jidx     = {braking, step_lim < cur_step};
    jerk_step = per_tick(regs[`DVM_R_JERK0 + 32'(jidx)]);
    if (!jerk_on)
      step_use = step_lim;
    else if (cur_step < step_lim)
      step_use = min_w(cur_step + jerk_step, step_lim); // [RQ1]
    else
      step_use = step_lim;
  end

  // Ramp generator and position integration
  dvm_word_t next_pos;
  dvm_word_t range;

  always_comb begin
    range    = regs[`DVM_R_POS_MAX] - regs[`DVM_R_POS_MIN] + 32'sh1;
    next_pos = pos + 32'(64'(dem) * 64'(`DVM_TICK_US) / 64'sh00000000000F4240);
    // Zero or negative range leaves the axis linear
    if (range > 32'sh0) begin
      if (next_pos > dvm_word_t'(regs[`DVM_R_POS_MAX]))
        next_pos = next_pos - range; // [RQ7]
      else if (next_pos < dvm_word_t'(regs[`DVM_R_POS_MIN]))
        next_pos = next_pos + range; // [RQ7]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dem      <= 32'sh0;
      cur_step <= 32'sh0;
      limited  <= 1'b0;
    end else if (tick) begin
      cur_step <= step_use;
      limited  <= clamped || (abs_w(err) > step_use); // [RQ11]
      if (state == DVM_POS && remain != 32'sh0 && abs_w(remain) <= abs_w(dem) / 32'sh3E8)
        dem <= remain[31] ? -end_v : end_v; // [RQ4]
      else if (abs_w(err) <= step_use)
        dem <= tgt; // [RQ24]
      else
        dem <= err[31] ? dem - step_use : dem + step_use; // [RQ24]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      pos <= 32'sh0;
    else if (tick && state == DVM_POS && remain != 32'sh0
             && abs_w(remain) <= abs_w(dem) / 32'sh3E8)
      pos <= regs[`DVM_R_TGT_POS]; // [RQ4]
    else if (tick)
      pos <= next_pos;
  end

  // Window, threshold and slippage timers in ticks
  dvm_word_t act;
  logic      in_win;
  logic      over_thr;
  logic      over_slip;

  always_comb begin
    act       = act_sync;
    in_win    = abs_w(act - (halt ? 32'sh0 : tgt)) <= dvm_word_t'(regs[`DVM_R_VEL_WIN]);
    over_thr  = abs_w(act) > dvm_word_t'(regs[`DVM_R_VEL_THR]);
    over_slip = abs_w(act - dem) > dvm_word_t'(regs[`DVM_R_MAX_SLIP]);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      win_cnt  <= 16'h0000;
      thr_cnt  <= 16'h0000;
      slip_cnt <= 16'h0000;
    end else if (tick) begin
      win_cnt  <= !in_win ? 16'h0000 : (win_cnt == 16'hFFFF) ? win_cnt : win_cnt + 16'h0001;
      thr_cnt  <= !over_thr ? 16'h0000 : (thr_cnt == 16'hFFFF) ? thr_cnt : thr_cnt + 16'h0001;
      slip_cnt <= !over_slip ? 16'h0000
                : (slip_cnt == 16'hFFFF) ? slip_cnt : slip_cnt + 16'h0001;
    end
  end

  // Status and demand outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_word     <= 16'h1000;
      demand_speed    <= 32'h00000000;
      demand_position <= 32'h00000000;
    end else begin
      demand_speed    <= dem;
      demand_position <= pos;
      status_word     <= 16'h0000;
      if (state == DVM_VL)
        status_word[`DVM_B_LIMIT] <= limited; // [RQ11]
      if (state == DVM_PV) begin
        // Halt set: bit low while braking, high at standstill
        status_word[`DVM_B_REACHED] <= (halt ? (dem == 32'sh0) : 1'b1)
          && (win_cnt >= regs[`DVM_R_VEL_WIN_T][15:0]) && in_win; // [RQ20] [RQ23]
        status_word[`DVM_B_ZERO] <= !(thr_cnt >= regs[`DVM_R_VEL_THR_T][15:0]
          && over_thr); // [RQ21]
      end else begin
        status_word[`DVM_B_ZERO] <= 1'b1;
      end
      if (regs[`DVM_R_CTRL][`DVM_B_CLOSED])
        status_word[`DVM_B_DEVIATE] <= over_slip
          && (slip_cnt > regs[`DVM_R_SLIP_T][15:0]); // [RQ22]
    end
  end

endmodule : dvm_mode_ctrl
`default_nettype wire

// ===== verification/dvm_mode_monitor.sv
// Port checker of the mode control block
`default_nettype none
`include "dvm_params.svh"
module dvm_mode_monitor
  import dvm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 40000
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Motion
  input wire logic        quick_stop_active,
  input wire logic [31:0] actual_speed,
  input wire logic [31:0] demand_speed,
  input wire logic [31:0] demand_position,
  input wire logic [15:0] status_word
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_STAT = 8'(`DVM_R_STATUS * 4);
  localparam logic [7:0] A_DEM  = 8'(`DVM_R_DEMAND * 4);
  localparam logic [7:0] A_POS  = 8'(`DVM_R_POSITION * 4);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic setup;
  assign setup = psel && !penable;
  a_ready_access: assert property (pready == (psel && penable))
    else $error("pready not tied to access phase");
  a_reset_state: assert property ($rose(reset_n) |-> status_word == 16'h1000 && demand_speed == 32'h0)
    else $error("wrong state after reset");
  // Needs TICK_CYCLES of at least nine
  a_demand_steady: assert property ($changed(demand_speed) |=> $stable(demand_speed) [*8])
    else $error("demand changed between ticks");
  a_unmapped_err: assert property (setup && (paddr[7:2] >= 6'h28 || paddr[1:0] != 2'h0)
    |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_ro_refused: assert property (setup && pwrite && (paddr == A_STAT || paddr == A_DEM
    || paddr == A_POS) |=> pslverr)
    else $error("write to read-only word accepted");
  a_mapped_ok: assert property (setup && !pwrite && paddr[7:2] < 6'h28 && paddr[1:0] == 2'h0
    |=> !pslverr)
    else $error("mapped read refused");
  a_status_read: assert property (setup && !pwrite && paddr == A_STAT
    |=> prdata == {16'h0000, $past(status_word)})
    else $error("status read mismatch");
  a_demand_read: assert property (setup && !pwrite && paddr == A_DEM
    |=> prdata == $past(demand_speed))
    else $error("demand read mismatch");
  a_position_read: assert property (setup && !pwrite && paddr == A_POS
    |=> prdata == $past(demand_position))
    else $error("position read mismatch");
  c_write: cover property (setup && pwrite);
  c_reached: cover property (status_word[10]);
  c_limit: cover property (status_word[11]);
  c_deviate: cover property (status_word[13]);
endmodule : dvm_mode_monitor
bind dvm_mode_ctrl dvm_mode_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_monitor (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .quick_stop_active(quick_stop_active), .actual_speed(actual_speed),
  .demand_speed(demand_speed), .demand_position(demand_position),
  .status_word(status_word));
`default_nettype wire

// ===== verification/dvm_motor_model.sv
// Power stage model: feedback follows demand one cycle late, plus a slip offset
`default_nettype none
module dvm_motor_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Drive side
  input  wire logic [31:0] demand_speed,
  input  wire logic [31:0] slip,
  output var  logic [31:0] actual_speed
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ideal stiff motor; slip stands in for load loss in closed loop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      actual_speed <= 32'h0;
    end else begin
      actual_speed <= demand_speed + slip;
    end
  end
endmodule : dvm_motor_model
`default_nettype wire

// ===== verification/drive_velocity_mode_control_tb.sv
// Testbench of the mode control block
`default_nettype none
`include "dvm_params.svh"
module drive_velocity_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 16;
  logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        quick_stop_active = 0, pready, pslverr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, slip = 32'h0, prdata, actual_speed;
  logic [31:0] demand_speed, demand_position;
  logic [15:0] status_word;
  int          bad_count = 0, checked = 0;
  dvm_mode_ctrl #(.TICK_CYCLES(TICK)) DUT (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .quick_stop_active(quick_stop_active), .actual_speed(actual_speed),
    .demand_speed(demand_speed), .demand_position(demand_position),
    .status_word(status_word));
  dvm_motor_model u_motor (.clk(clk), .reset_n(reset_n), .demand_speed(demand_speed),
    .slip(slip), .actual_speed(actual_speed));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic complete_run;
    $display("mismatches %0d, comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input int idx, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= 8'(idx * 4);
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    // A slave that never answers counts against the run
    if (n >= 50) bad_count++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wreg(input int idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask : wreg
  task automatic rdc(input int idx, input logic [31:0] exp, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0, r, e);
    check(r, exp);
    check({31'h0, e}, {31'h0, xe});
  endtask : rdc
  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge clk);
  endtask : ticks
  // Bounded wait for the next demand update, then let status settle
  task automatic step_wait;
    logic [31:0] old;
    int          n;
    old = demand_speed;
    n = 0;
    while (demand_speed === old && n < 4 * TICK) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
  endtask : step_wait
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    complete_run;
  end
  initial begin
    logic [31:0] r;
    logic        e;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdc(`DVM_R_PROF_TYPE, 32'h0, 1'b0);
    rdc(`DVM_R_DIM_MUL, 32'h1, 1'b0);
    rdc(`DVM_R_DIM_DIV, 32'h1, 1'b0);
    rdc(40, 32'h0, 1'b1);
    apb(1'b1, `DVM_R_STATUS, 32'hFFFF, r, e);
    check({31'h0, e}, 32'h1);
    rdc(`DVM_R_STATUS, 32'h1000, 1'b0);
    // Profile velocity, cap 3000 below motor limit
    wreg(`DVM_R_TGT_PV, 32'h1388);
    wreg(`DVM_R_MAX_PVEL, 32'hBB8);
    wreg(`DVM_R_MAX_MOTOR, 32'hFA0);
    wreg(`DVM_R_PROF_ACC, 32'hF4240);
    wreg(`DVM_R_PROF_DEC, 32'hF4240);
    wreg(`DVM_R_MAX_ACC, 32'hF4240);
    wreg(`DVM_R_MAX_DEC, 32'h989680);
    wreg(`DVM_R_QS_DEC, 32'h2DC6C0);
    wreg(`DVM_R_VEL_WIN, 32'hA);
    wreg(`DVM_R_VEL_WIN_T, 32'h2);
    wreg(`DVM_R_VEL_THR, 32'h64);
    wreg(`DVM_R_VEL_THR_T, 32'h1);
    wreg(`DVM_R_MODE, 32'h3);
    step_wait;
    check(demand_speed, 32'h3E8);
    ticks(8);
    check(demand_speed, 32'hBB8);
    check({29'h0, status_word[12:10]}, 32'h1);
    wreg(`DVM_R_CTRL, 32'h100);
    step_wait;
    check(demand_speed, 32'h7D0);
    check({29'h0, status_word[12:10]}, 32'h0);
    ticks(6);
    check({20'h0, status_word[12:10], demand_speed[8:0]}, 32'h00000A00);
    wreg(`DVM_R_CTRL, 32'h0);
    ticks(6);
    check(demand_speed, 32'hBB8);
    quick_stop_active <= 1'b1;
    step_wait;
    check(demand_speed, 32'h0);
    rdc(`DVM_R_DEMAND, 32'h0, 1'b0);
    apb(1'b0, `DVM_R_POSITION, 32'h0, r, e);
    // Velocity mode, jerk type set but must be ignored
    wreg(`DVM_R_PROF_TYPE, 32'h3);
    wreg(`DVM_R_VL_ACC_DS, 32'h186A0);
    wreg(`DVM_R_VL_ACC_DT, 32'h1);
    wreg(`DVM_R_VL_DEC_DS, 32'h30D40);
    wreg(`DVM_R_VL_DEC_DT, 32'h1);
    wreg(`DVM_R_VL_QS_DS, 32'h493E0);
    wreg(`DVM_R_VL_QS_DT, 32'h1);
    wreg(`DVM_R_VL_MIN, 32'h12C);
    wreg(`DVM_R_VL_MAX, 32'h3E8);
    wreg(`DVM_R_TGT_VL, 32'h32);
    wreg(`DVM_R_MODE, 32'h2);
    quick_stop_active <= 1'b0;
    step_wait;
    check(demand_speed, 32'h64);
    check({29'h0, status_word[12:10]}, 32'h6);
    ticks(4);
    check(demand_speed, 32'h12C);
    check({29'h0, status_word[12:10]}, 32'h6);
    wreg(`DVM_R_TGT_VL, 32'h1388);
    ticks(10);
    check(demand_speed, 32'h3E8);
    wreg(`DVM_R_CTRL, 32'h100);
    step_wait;
    check(demand_speed, 32'h320);
    ticks(6);
    check(demand_speed, 32'h0);
    wreg(`DVM_R_CTRL, 32'h0);
    step_wait;
    check(demand_speed, 32'h64);
    wreg(`DVM_R_DIM_MUL, 32'h3);
    wreg(`DVM_R_DIM_DIV, 32'h2);
    wreg(`DVM_R_TGT_VL, 32'h190);
    ticks(8);
    check(demand_speed, 32'h258);
    check({29'h0, status_word[12:10]}, 32'h4);
    quick_stop_active <= 1'b1;
    step_wait;
    check(demand_speed, 32'h12C);
    quick_stop_active <= 1'b0;
    // Closed loop with feedback running 500 above demand
    wreg(`DVM_R_MAX_SLIP, 32'h32);
    wreg(`DVM_R_SLIP_T, 32'h2);
    wreg(`DVM_R_CTRL, 32'h1);
    slip <= 32'h1F4;
    ticks(6);
    check({31'h0, status_word[13]}, 32'h1);
    rdc(`DVM_R_STATUS, 32'h3000, 1'b0);
    complete_run;
  end
endmodule : drive_velocity_mode_control_tb
`default_nettype wire
